/* cfg_port_pkg.sv */
package cfg_port_pkg;
    localparam logic [7:0]  APB_CTRL      = 8'h00;
    localparam logic [7:0]  APB_STATUS    = 8'h04;
    localparam logic [7:0]  APB_FRAMES    = 8'h08;
    localparam int          CTRL_PD_BIT   = 0;
    localparam logic [7:0]  CTRL_RESET    = 8'h00;
    localparam int          INSTR_BITS    = 16;
    localparam int          INSTR_RW_BIT  = 15;
    localparam int          INSTR_WL_HI   = 14;
    localparam int          INSTR_WL_LO   = 13;
    localparam int          ADDR_BITS     = 13;
    localparam int          BYTE_BITS     = 8;
    localparam logic [1:0]  WL_STREAM     = 2'h3;
    localparam logic [12:0] ADDR_PORTCFG  = 13'h0000;
    localparam logic [12:0] ADDR_CHIPID   = 13'h0001;
    localparam logic [7:0]  PORTCFG_RESET = 8'h18;
    localparam logic [7:0]  PORTCFG_FIXED = 8'h18;
    localparam logic [7:0]  PORTCFG_LSB   = 8'h42;
    localparam logic [7:0]  PORTCFG_SRST  = 8'h24;
    localparam logic [15:0] PATTERN_WORD  = 16'h8000;
    localparam logic [1:0]  BOOT_CYCLES   = 2'h3;
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_INSTR = 3'b010,
        ST_DATA  = 3'b100
    } frame_state_type;
endpackage : cfg_port_pkg

/* pin_sync_if.sv */
`timescale 1ns/10ps
interface pin_sync_if #(parameter int WIDTH = 5);
    logic [WIDTH-1:0] raw;
    logic [WIDTH-1:0] synced;
    modport sync_side (input raw, output synced);
    modport user_side (output raw, input synced);
endinterface : pin_sync_if

/* pin_sync.sv */
`timescale 1ns/10ps
module pin_sync #(
    parameter int                   WIDTH      = 5,
    parameter logic [WIDTH-1:0]     RESET_VAL  = '0
) (
    input  wire logic               pclk,
    input  wire logic               presetn,
    pin_sync_if.sync_side           pins
);
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] sync_r;

    // first stage feeds only the second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r <= RESET_VAL;
            sync_r <= RESET_VAL;
        end else begin
            meta_r <= pins.raw;
            sync_r <= meta_r;
        end
    end

    assign pins.synced = sync_r;
endmodule : pin_sync

/* cfg_serial_port.sv */
// The APB register port and the placing of the registers were decided locally.
`timescale 1ns/10ps
module cfg_serial_port
    import cfg_port_pkg::*;
#(
    parameter int          REG_DEPTH = 16,
    parameter logic [7:0]  CHIP_CODE = 8'h5a  // arbitrary value
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        bank1_select_n,
    input  wire logic        bank2_select_n,
    input  wire logic        serial_clock_or_pattern_strap,
    input  wire logic        serial_data_or_lane_strap_in,
    output logic             serial_data_or_lane_strap_out,
    output logic             serial_data_or_lane_strap_oe,
    input  wire logic        powerdown_pin,
    output logic             powerdown_out,
    output logic             lane_two_out,
    output logic             test_pattern_out,
    output logic [15:0]      pattern_word
);
    localparam int AW = $clog2(REG_DEPTH);

    initial begin
        if (REG_DEPTH < 4 || (1 << AW) != REG_DEPTH)
            $error("REG_DEPTH must be a power of two, at least 4");
    end

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers

    pin_sync_if #(.WIDTH(5)) pins ();

    assign pins.raw = {powerdown_pin, bank2_select_n, bank1_select_n,
                       serial_data_or_lane_strap_in,
                       serial_clock_or_pattern_strap};

    pin_sync #(.WIDTH(5), .RESET_VAL(5'h0c)) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .pins    (pins)
    );

    logic s_sclk;
    logic s_sdio;
    logic s_b1n;
    logic s_b2n;
    logic s_pd;

    assign {s_pd, s_b2n, s_b1n, s_sdio, s_sclk} = pins.synced;

    ////////////////////////////////////////////////////////////////////
    // power-up strap capture

    logic [1:0] boot_cnt_r;
    logic       boot_done_r;
    logic       strap_mode_r;
    logic       pattern_cap_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            boot_cnt_r    <= 2'h0;
            boot_done_r   <= 1'b0;
            strap_mode_r  <= 1'b0;
            pattern_cap_r <= 1'b0;
        end else if (!boot_done_r) begin
            boot_cnt_r <= boot_cnt_r + 2'h1;
            // synchronisers hold real pin levels by now
            if (boot_cnt_r == BOOT_CYCLES - 2'h1) begin
                boot_done_r   <= 1'b1;
                strap_mode_r  <= s_b1n & s_b2n;
                pattern_cap_r <= s_b1n & s_b2n & s_sclk;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // edge detection

    logic sclk_prev_r;
    logic sel_prev_r;
    logic any_sel;
    logic active;
    logic rise;
    logic fall;
    logic start;

    assign any_sel = ~s_b1n | ~s_b2n;
    assign active  = any_sel & boot_done_r & ~strap_mode_r;
    assign rise    = s_sclk & ~sclk_prev_r & active;
    assign fall    = ~s_sclk & sclk_prev_r & active;
    assign start   = any_sel & ~sel_prev_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_prev_r <= 1'b0;
            sel_prev_r  <= 1'b0;
        end else begin
            sclk_prev_r <= s_sclk;
            sel_prev_r  <= any_sel;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // register storage, one array per bank

    logic [7:0] bank1_mem [REG_DEPTH];
    logic [7:0] bank2_mem [REG_DEPTH];
    logic [7:0] portcfg_r;
    logic       lsb_first;

    assign lsb_first = |(portcfg_r & PORTCFG_LSB);

    function automatic logic [7:0] flip8(input logic [7:0] v);
        logic [7:0] r;
        r = '0;
        for (int i = 0; i < 8; i++) begin
            r[i] = v[7-i];
        end
        return r;
    endfunction : flip8

    function automatic logic [7:0] read_byte(input logic [12:0] a,
                                             input logic        b1);
        logic [7:0] r;
        r = 8'h00;
        if (a == ADDR_PORTCFG)
            r = portcfg_r;
        else if (a == ADDR_CHIPID)
            r = CHIP_CODE;
        else if (a < 13'(REG_DEPTH))
            r = b1 ? bank1_mem[a[AW-1:0]] : bank2_mem[a[AW-1:0]];
        return r;
    endfunction : read_byte

    ////////////////////////////////////////////////////////////////////
    // frame engine

    frame_state_type state_r;
    logic [3:0]      bit_cnt_r;
    logic [15:0]     shift_r;
    logic            rw_r;
    logic [1:0]      wlen_r;
    logic [12:0]     addr_r;
    logic [1:0]      left_r;
    logic [7:0]      tx_r;
    logic [15:0]     frames_r;
    logic [15:0]     instr;
    logic [7:0]      rx_byte;
    logic            byte_done;
    logic            wr_byte;
    logic [12:0]     addr_step;

    assign instr     = {shift_r[14:0], s_sdio};
    assign rx_byte   = lsb_first ? flip8(instr[7:0]) : instr[7:0];
    assign byte_done = (state_r == ST_DATA) && rise
                       && (bit_cnt_r == 4'(BYTE_BITS - 1));
    assign wr_byte   = byte_done && !rw_r;
    // address walks down in msb-first mode, up in lsb-first mode
    assign addr_step = lsb_first ? addr_r + 13'h1 : addr_r - 13'h1;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r   <= ST_IDLE;
            bit_cnt_r <= 4'h0;
            shift_r   <= 16'h0000;
            rw_r      <= 1'b0;
            wlen_r    <= 2'h0;
            addr_r    <= 13'h0000;
            left_r    <= 2'h0;
            tx_r      <= 8'h00;
            frames_r  <= 16'h0000;
        end else begin
            unique case (state_r)
                ST_IDLE: begin
                    if (start && active) begin
                        state_r   <= ST_INSTR;
                        bit_cnt_r <= 4'h0;
                    end
                end
                ST_INSTR: begin
                    // deselect only pauses; bits resume later
                    if (rise) begin
                        shift_r   <= instr;
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                        if (bit_cnt_r == 4'(INSTR_BITS - 1)) begin
                            state_r   <= ST_DATA;
                            bit_cnt_r <= 4'h0;
                            rw_r      <= instr[INSTR_RW_BIT];
                            wlen_r    <= instr[INSTR_WL_HI:INSTR_WL_LO];
                            left_r    <= instr[INSTR_WL_HI:INSTR_WL_LO];
                            addr_r    <= instr[ADDR_BITS-1:0];
                            tx_r      <= read_byte(instr[ADDR_BITS-1:0],
                                                   ~s_b1n);
                        end
                    end
                end
                ST_DATA: begin
                    if (wlen_r == WL_STREAM && !any_sel) begin
                        state_r  <= ST_IDLE;
                        frames_r <= frames_r + 16'h1;
                    end else if (rise) begin
                        shift_r   <= instr;
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                        if (byte_done) begin
                            bit_cnt_r <= 4'h0;
                            addr_r    <= addr_step;
                            tx_r      <= read_byte(addr_step, ~s_b1n);
                            if (wlen_r != WL_STREAM
                                && left_r == 2'h0) begin
                                state_r  <= ST_IDLE;
                                frames_r <= frames_r + 16'h1;
                            end else if (wlen_r != WL_STREAM) begin
                                left_r <= left_r - 2'h1;
                            end
                        end
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // register writes and soft reset

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            portcfg_r <= PORTCFG_RESET;
            for (int i = 0; i < REG_DEPTH; i++) begin
                bank1_mem[i] <= 8'h00;
                bank2_mem[i] <= 8'h00;
            end
        end else if (wr_byte) begin
            if (addr_r == ADDR_PORTCFG) begin
                if (|(rx_byte & PORTCFG_SRST)) begin
                    // reset bits never stick, so they read back clear
                    portcfg_r <= PORTCFG_RESET;
                    for (int i = 0; i < REG_DEPTH; i++) begin
                        bank1_mem[i] <= 8'h00;
                        bank2_mem[i] <= 8'h00;
                    end
                end else begin
                    portcfg_r <= (rx_byte & PORTCFG_LSB)
                                 | PORTCFG_FIXED;
                end
            end else if (addr_r != ADDR_CHIPID
                         && addr_r < 13'(REG_DEPTH)) begin
                if (!s_b1n)
                    bank1_mem[addr_r[AW-1:0]] <= rx_byte;
                if (!s_b2n)
                    bank2_mem[addr_r[AW-1:0]] <= rx_byte;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read data drive

    logic sdo_r;
    logic sdo_oe_r;
    logic [2:0] tx_idx;

    assign tx_idx = lsb_first ? bit_cnt_r[2:0] : 3'h7 - bit_cnt_r[2:0];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sdo_r    <= 1'b0;
            sdo_oe_r <= 1'b0;
        end else if (!active || state_r != ST_DATA || !rw_r) begin
            sdo_oe_r <= 1'b0;
        end else if (fall) begin
            // first fall after the last address bit turns the line
            sdo_oe_r <= 1'b1;
            sdo_r    <= tx_r[tx_idx];
        end
    end

    assign serial_data_or_lane_strap_out = sdo_r;
    assign serial_data_or_lane_strap_oe  = sdo_oe_r;

    ////////////////////////////////////////////////////////////////////
    // static controls

    logic       pd_out_r;
    logic       lane_r;
    logic       pat_r;
    logic [15:0] pat_word_r;
    logic [7:0] ctrl_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pd_out_r   <= 1'b0;
            lane_r     <= 1'b1;
            pat_r      <= 1'b0;
            pat_word_r <= 16'h0000;
        end else if (strap_mode_r) begin
            pd_out_r   <= s_pd;
            lane_r     <= s_sdio;
            pat_r      <= pattern_cap_r;
            pat_word_r <= pattern_cap_r ? PATTERN_WORD : 16'h0000;
        end else begin
            pd_out_r   <= s_pd | ctrl_r[CTRL_PD_BIT];
            lane_r     <= 1'b1;
            pat_r      <= 1'b0;
            pat_word_r <= 16'h0000;
        end
    end

    assign powerdown_out    = pd_out_r;
    assign lane_two_out     = lane_r;
    assign test_pattern_out = pat_r;
    assign pattern_word     = pat_word_r;

    ////////////////////////////////////////////////////////////////////
    // apb slave, zero wait states

    logic [31:0] prdata_r;
    logic        pready_r;
    logic        pslverr_r;
    logic        mapped;
    logic [31:0] rd_mux;

    always_comb begin
        mapped = 1'b1;
        rd_mux = 32'h0000_0000;
        unique case (paddr)
            APB_CTRL:   rd_mux = {24'h000000, ctrl_r};
            APB_STATUS: rd_mux = {25'h0000000, state_r != ST_IDLE,
                                  sdo_oe_r, lane_r, pat_r, pd_out_r,
                                  boot_done_r, strap_mode_r};
            APB_FRAMES: rd_mux = {16'h0000, frames_r};
            default:    mapped = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_r  <= 1'b0;
            prdata_r  <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else begin
            pready_r  <= psel & ~penable;
            prdata_r  <= (psel & ~penable & ~pwrite) ? rd_mux
                                                      : 32'h0000_0000;
            pslverr_r <= psel & ~penable & ~mapped;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            ctrl_r <= CTRL_RESET;
        else if (psel && penable && pready_r && pwrite
                 && paddr == APB_CTRL)
            ctrl_r <= {7'h00, pwdata[CTRL_PD_BIT]};
    end

    assign prdata  = prdata_r;
    assign pready  = pready_r;
    assign pslverr = pslverr_r;

    ////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_IGNORE_DESELECT: assert property (
        state_r == ST_INSTR && !active |=> $stable(bit_cnt_r)
    ) else $error("bit counted while deselected");

    AST_FRAME_START: assert property (
        state_r == ST_IDLE && start && active |=> state_r == ST_INSTR
    ) else $error("frame did not start on select fall");

    AST_INSTR_LEN: assert property (
        state_r == ST_INSTR && rise && bit_cnt_r == 4'hf
        |=> state_r == ST_DATA && bit_cnt_r == 4'h0
    ) else $error("instruction phase not sixteen bits");

    AST_RW_DECODE: assert property (
        state_r == ST_INSTR && rise && bit_cnt_r == 4'hf
        |=> rw_r == $past(shift_r[14])
    ) else $error("read flag not taken from first bit");

    AST_WORD_LEN: assert property (
        byte_done && wlen_r != WL_STREAM && left_r == 2'h0
        |=> state_r == ST_IDLE
    ) else $error("frame length ignores word-length bits");

    AST_TURNAROUND: assert property (
        state_r == ST_DATA && rw_r && fall |=> sdo_oe_r
    ) else $error("read data not driven after address");

    AST_STRAP_HIZ: assert property (
        strap_mode_r |-> !sdo_oe_r && state_r == ST_IDLE
    ) else $error("serial port active in strap mode");

    AST_PD_PIN: assert property (
        boot_done_r && !strap_mode_r && s_pd |=> pd_out_r
    ) else $error("powerdown pin ignored in serial mode");

    AST_SRST_CLEAR: assert property (
        !(|(portcfg_r & PORTCFG_SRST))
    ) else $error("soft reset bit stuck");

endmodule : cfg_serial_port

/* cfg_ctl_model.sv */
`timescale 1ns/10ps
module cfg_ctl_model (
    output logic      sclk,
    output logic      sel1_n,
    output logic      sel2_n,
    output logic      mosi,
    output logic      drv,
    input  wire logic sdio
);
    localparam int HALF = 32;
    ////////////////////////////////////////////////////////////////////////
    initial begin
        sclk   = 1'b0;
        sel1_n = 1'b0;
        sel2_n = 1'b0;
        mosi   = 1'b1;
        drv    = 1'b1;
    end
    // pin levels held through reset and boot
    task automatic strap(input logic [1:0] sel_n, input logic clk_lvl,
                         input logic dat_lvl);
        {sel2_n, sel1_n} = sel_n;
        sclk = clk_lvl;
        mosi = dat_lvl;
        drv = 1'b1;
    endtask : strap
    ////////////////////////////////////////////////////////////////////////
    // clock stands low outside frames
    task automatic frame(input logic [1:0] banks_n, input logic [15:0] instr,
                         input logic [7:0] wbyte, input logic pause,
                         output logic [7:0] rbyte);
        int i;
        {sel2_n, sel1_n} = 2'b11;
        sclk = 1'b0;
        drv = 1'b1;
        #(2*HALF);
        {sel2_n, sel1_n} = banks_n;
        for (i = 15; i >= 0; i--) begin
            mosi = instr[i];
            #HALF sclk = 1'b1;
            #HALF sclk = 1'b0;
        end
        if (instr[15]) drv = 1'b0;
        if (pause) begin
            {sel2_n, sel1_n} = 2'b11;
            #(4*HALF);
            {sel2_n, sel1_n} = banks_n;
        end
        for (i = 7; i >= 0; i--) begin
            // released line toggles so a stale value never passes
            mosi = drv ? wbyte[i] : ~mosi;
            #HALF sclk = 1'b1;
            rbyte[i] = sdio;
            #HALF sclk = 1'b0;
        end
        #HALF;
        {sel2_n, sel1_n} = 2'b11;
        drv = 1'b1;
    endtask : frame
endmodule : cfg_ctl_model

/* adc_config_serial_port_tb.sv */
`timescale 1ns/10ps
module adc_config_serial_port_tb
    import cfg_port_pkg::*;
;
    localparam logic [7:0] CHIP_VAL = 8'h3c; // arbitrary value
    typedef struct packed {
        logic        wr;
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic [31:0] exp_rd;
        logic        exp_err;
    } apb_row_type;
    apb_row_type rows [8];
    logic        pclk, presetn, psel, penable, pwrite, powerdown_pin;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, sdo, oe, err, powerdown_out;
    logic        lane_two_out, test_pattern_out, sclk, sel1_n, sel2_n;
    logic        mosi, drv, sdio;
    logic        toggle_r = 1'b0;
    logic [15:0] pattern_word;
    logic [7:0]  got;
    int          mismatches, tests_run, oe_cycles, base;
    ////////////////////////////////////////////////////////////////////////
    cfg_serial_port #(.REG_DEPTH(16), .CHIP_CODE(CHIP_VAL)) DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .bank1_select_n(sel1_n),
        .bank2_select_n(sel2_n), .serial_clock_or_pattern_strap(sclk),
        .serial_data_or_lane_strap_in(sdio),
        .serial_data_or_lane_strap_out(sdo),
        .serial_data_or_lane_strap_oe(oe), .powerdown_pin(powerdown_pin),
        .powerdown_out(powerdown_out), .lane_two_out(lane_two_out),
        .test_pattern_out(test_pattern_out), .pattern_word(pattern_word));
    cfg_ctl_model ctl (.sclk(sclk), .sel1_n(sel1_n), .sel2_n(sel2_n),
        .mosi(mosi), .drv(drv), .sdio(sdio));
    assign sdio = (oe === 1'b1) ? sdo : (drv ? mosi : toggle_r);
    ////////////////////////////////////////////////////////////////////////
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    initial begin
        #200000;
        mismatches++;
        wrap_up();
    end
    always @(posedge pclk) begin
        toggle_r <= ~toggle_r;
        if (oe === 1'b1) begin
            oe_cycles++;
            check({31'h0, drv}, 32'h0, "line contention");
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                         input string what);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %0t %s: %h vs %h", $time, what, seen, exp);
        end
    endtask : check
    task automatic wrap_up();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : wrap_up
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (n = 0; n < 16; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (n == 16) begin
            mismatches++;
            wrap_up();
        end
    endtask : apb
    task automatic ser(input logic [1:0] bn, input logic r,
                       input logic [12:0] a, input logic [7:0] wb,
                       input logic ps, input logic [7:0] exp);
        ctl.frame(bn, {r, 2'b00, a}, wb, ps, got);
        if (r) check({24'h0, got}, {24'h0, exp}, "serial read");
    endtask : ser
    task automatic settle(input logic pd);
        powerdown_pin <= pd;
        repeat (8) @(posedge pclk);
    endtask : settle
    ////////////////////////////////////////////////////////////////////////
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        powerdown_pin = 1'b0;
        rows = '{'{1'b1, APB_CTRL, 32'hffffffff, 32'h0, 1'b0},
                 '{1'b0, APB_CTRL, 32'h0, 32'h1, 1'b0},
                 '{1'b0, APB_STATUS, 32'h0, 32'h16, 1'b0},
                 '{1'b1, APB_CTRL, 32'h0, 32'h0, 1'b0},
                 '{1'b0, APB_STATUS, 32'h0, 32'h12, 1'b0},
                 '{1'b0, APB_FRAMES, 32'h0, 32'h0, 1'b0},
                 '{1'b1, 8'h0c, 32'hffffffff, 32'h0, 1'b1},
                 '{1'b0, 8'h0c, 32'h0, 32'h0, 1'b1}};
        ctl.strap(2'b00, 1'b0, 1'b1);
        repeat (10) @(posedge pclk);
        check({31'h0, pready}, 32'h0, "pready in reset");
        check({31'h0, lane_two_out}, 32'h1, "lane in reset");
        presetn <= 1'b1;
        repeat (6) @(posedge pclk);
        foreach (rows[i]) begin
            apb(rows[i].wr, rows[i].addr, rows[i].wdata);
            if (!rows[i].wr) check(rd, rows[i].exp_rd, "apb read");
            check({31'h0, err}, {31'h0, rows[i].exp_err}, "apb error");
        end
        $display("test register table done");
        ser(2'b00, 1'b0, 13'h2, 8'ha5, 1'b0, 8'h00);
        ser(2'b10, 1'b1, 13'h2, 8'h00, 1'b0, 8'ha5);
        check({31'h0, oe_cycles != 0}, 32'h1, "no turnaround");
        ser(2'b10, 1'b1, ADDR_CHIPID, 8'h00, 1'b0, CHIP_VAL);
        ser(2'b01, 1'b0, 13'h3, 8'h5c, 1'b1, 8'h00);
        ser(2'b10, 1'b1, 13'h3, 8'h00, 1'b0, 8'h00);
        ser(2'b01, 1'b1, 13'h3, 8'h00, 1'b0, 8'h5c);
        $display("test serial banks done");
        ser(2'b00, 1'b0, 13'h4, 8'h01, 1'b0, 8'h00);
        ser(2'b00, 1'b0, ADDR_PORTCFG, PORTCFG_LSB, 1'b0, 8'h00);
        ser(2'b10, 1'b1, 13'h4, 8'h00, 1'b0, 8'h80);
        ser(2'b00, 1'b0, ADDR_PORTCFG, PORTCFG_SRST, 1'b0, 8'h00);
        ser(2'b10, 1'b1, ADDR_PORTCFG, 8'h00, 1'b0, PORTCFG_RESET);
        ser(2'b10, 1'b1, 13'h4, 8'h00, 1'b0, 8'h00);
        apb(1'b0, APB_FRAMES, 32'h0);
        check(rd, 32'hc, "frame count");
        $display("test bit order and soft reset done");
        settle(1'b1);
        check({31'h0, powerdown_out}, 32'h1, "pin powerdown");
        settle(1'b0);
        check({31'h0, powerdown_out}, 32'h0, "pin released");
        $display("test powerdown pin done");
        presetn <= 1'b0;
        ctl.strap(2'b11, 1'b1, 1'b0);
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        repeat (10) @(posedge pclk);
        check({31'h0, test_pattern_out}, 32'h1, "pattern strap");
        check({16'h0, pattern_word}, {16'h0, PATTERN_WORD}, "word");
        check({31'h0, lane_two_out}, 32'h0, "one lane strap");
        settle(1'b1);
        check({31'h0, powerdown_out}, 32'h1, "static powerdown");
        base = oe_cycles;
        ctl.frame(2'b10, {1'b1, 2'b00, ADDR_CHIPID}, 8'h00, 1'b0, got);
        check(32'(oe_cycles - base), 32'h0, "port not off");
        $display("test strap mode done");
        wrap_up();
    end
endmodule : adc_config_serial_port_tb
